// [logic/tscs_pkg.sv]
// package: constants and carrier types for the two-speed clock switch
package tscs_pkg;
    // oscillator control register (word offsets are byte addresses)
    localparam logic [3:0] OFS_OSC_CTRL = 4'h0;
    localparam logic [3:0] OFS_CONFIG = 4'h4;
    localparam int SEL_BIT = 0;
    localparam int STATUS_BIT = 3;
    localparam int IFREQ_LSB = 4;
    localparam int IFREQ_W = 3;
    localparam logic [2:0] IFREQ_RESET = 3'h6;
    // config register fields
    localparam int FOSC_LSB = 0;
    localparam int FOSC_W = 3;
    localparam int SWITCHOVER_BIT = 8;
    localparam int PUT_EN_BIT = 9;
    localparam logic [2:0] FOSC_RESET = 3'h1;
    localparam logic SWITCHOVER_RESET = 1'b1;
    localparam logic PUT_EN_RESET = 1'b0;
    localparam logic [2:0] MODE_LOW_POWER = 3'h0;
    localparam logic [2:0] MODE_CRYSTAL = 3'h1;
    localparam logic [2:0] MODE_HIGH_SPEED = 3'h2;
    // start-up counts
    localparam int STARTUP_COUNT = 1024;
    localparam int PUT_MS = 64;
    localparam int CLK_MHZ = 125;
    localparam int PUT_CYCLES = PUT_MS * 1000 * CLK_MHZ;
    // unmapped reads
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_POWER_UP = 3'b000,
        ST_RUN_EXT = 3'b001,
        ST_COUNT = 3'b010,
        ST_WAIT_INT_FALL = 3'b011,
        ST_HOLD_LOW = 3'b100,
        ST_SLEEP = 3'b101
    } tscs_state_t;

    typedef struct packed {
        logic int_osc;
        logic ext_osc;
    } tscs_osc_t;
endpackage

// [logic/tscs_switch.sv]
// two-speed start-up clock source switch with avalon-mm registers
//
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - with the select bit clear the system clock follows the configured oscillator mode.
// - with the select bit set the system clock runs from the internal oscillator in every state but hold-low, where it is held low.
// - every reset clears the select bit.
// - automatic switching never alters the select bit.
// - the status bit at position 3 shows whether the sequencer is in hold-low or external run, whatever the select bit.
// - in the crystal modes the status bit rises only after the start-up timer expires.
// - sleep during start-up aborts the count and keeps the status bit clear.
// - in a crystal mode without two-speed start-up and with the select bit clear, execution is held until 1024 external cycles are counted.
// - with two-speed start-up, code runs internally while counting, then moves external.
// - two-speed start-up needs switchover enabled, select bit clear and a crystal mode.
// - two-speed start-up begins after power-on (after the power-up timer) and each wake-up.
// - non-crystal modes skip the start-up wait entirely.
// - under two-speed start-up execution starts at once on the internal oscillator.
// - under two-speed start-up, after expiry the status bit waits for a falling edge of the internal oscillator; otherwise it goes to hold-low at once.
// - once set, the clock is held low until the external clock falls, then switches.
module tscs_switch #(
    parameter int PUT_CYC = tscs_pkg::PUT_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire tscs_pkg::tscs_osc_t osc_in,
    input wire logic sleep_req,
    input wire logic wake_req,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic sys_clk,
    output logic exec_en,
    output logic [2:0] int_freq_out
);
    // oscillator pins: two synchroniser stages, then an edge history stage
    tscs_pkg::tscs_osc_t sync1_ff;
    tscs_pkg::tscs_osc_t sync2_ff;
    tscs_pkg::tscs_osc_t prev_ff;

    always_ff @(posedge clk) begin
        sync1_ff <= osc_in;
    end

    always_ff @(posedge clk) begin
        sync2_ff <= sync1_ff;
    end

    always_ff @(posedge clk) begin
        prev_ff <= sync2_ff;
    end

    // edges found on synchronised levels only
    wire logic int_fall = prev_ff.int_osc & ~sync2_ff.int_osc;
    wire logic ext_fall = prev_ff.ext_osc & ~sync2_ff.ext_osc;
    wire logic ext_rise = ~prev_ff.ext_osc & sync2_ff.ext_osc;

    // software-visible bits
    logic sel_ff;
    logic [2:0] ifreq_ff;
    logic [2:0] fosc_ff;
    logic switchover_ff;
    logic put_en_ff;
    logic status_ff;

    // start-up sequencer state
    tscs_pkg::tscs_state_t state_ff;
    tscs_pkg::tscs_state_t nxt_state;
    logic [10:0] su_cnt_ff;
    logic [10:0] nxt_su_cnt;
    logic [31:0] put_cnt_ff;

    // bus side
    logic [31:0] avs_readdata_ff;
    logic avs_wait_ff;

    // avalon decode: taken with waitrequest high, answered one cycle later
    wire logic req = avs_read | avs_write;
    wire logic take = req & avs_wait_ff;
    wire logic ack = req & ~avs_wait_ff;
    wire logic sel_ctrl = avs_address == tscs_pkg::OFS_OSC_CTRL;
    wire logic sel_cfg = avs_address == tscs_pkg::OFS_CONFIG;
    // writes land at the edge where the master sees waitrequest low
    wire logic wr_ctrl = ack & avs_write & sel_ctrl;
    wire logic wr_cfg = ack & avs_write & sel_cfg;
    wire logic rd_take = take & avs_read;

    // readback words
    wire logic [31:0] rd_ctrl = {
        24'h0,
        1'b0,
        ifreq_ff,
        status_ff,
        2'h0,
        sel_ff
    };
    wire logic [31:0] rd_cfg = {
        22'h0,
        put_en_ff,
        switchover_ff,
        5'h0,
        fosc_ff
    };
    wire logic [31:0] rd_mux = sel_ctrl ? rd_ctrl
        : (sel_cfg ? rd_cfg : tscs_pkg::RD_UNMAPPED);

    // waitrequest: high when idle, low for one cycle to answer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            avs_wait_ff <= 1'b1;
        end else begin
            avs_wait_ff <= ~take;
        end
    end

    // read data captured when taken, stands until the next read
    always_ff @(posedge clk) begin
        if (!nrst) begin
            avs_readdata_ff <= 32'h0;
        end else if (rd_take) begin
            avs_readdata_ff <= rd_mux;
        end
    end

    // select bit: only software writes and reset touch it
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sel_ff <= 1'b0;
        end else if (wr_ctrl) begin
            sel_ff <= avs_writedata[tscs_pkg::SEL_BIT];
        end
    end

    // internal frequency select
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ifreq_ff <= tscs_pkg::IFREQ_RESET;
        end else if (wr_ctrl) begin
            ifreq_ff <= avs_writedata[tscs_pkg::IFREQ_LSB +: tscs_pkg::IFREQ_W];
        end
    end

    // oscillator mode configuration
    always_ff @(posedge clk) begin
        if (!nrst) begin
            fosc_ff <= tscs_pkg::FOSC_RESET;
        end else if (wr_cfg) begin
            fosc_ff <= avs_writedata[tscs_pkg::FOSC_LSB +: tscs_pkg::FOSC_W];
        end
    end

    // switchover enable
    always_ff @(posedge clk) begin
        if (!nrst) begin
            switchover_ff <= tscs_pkg::SWITCHOVER_RESET;
        end else if (wr_cfg) begin
            switchover_ff <= avs_writedata[tscs_pkg::SWITCHOVER_BIT];
        end
    end

    // power-up timer enable
    always_ff @(posedge clk) begin
        if (!nrst) begin
            put_en_ff <= tscs_pkg::PUT_EN_RESET;
        end else if (wr_cfg) begin
            put_en_ff <= avs_writedata[tscs_pkg::PUT_EN_BIT];
        end
    end

    // mode decode
    wire logic is_low_power = fosc_ff == tscs_pkg::MODE_LOW_POWER;
    wire logic is_crystal = fosc_ff == tscs_pkg::MODE_CRYSTAL;
    wire logic is_high_speed = fosc_ff == tscs_pkg::MODE_HIGH_SPEED;
    wire logic crystal = is_low_power | is_crystal | is_high_speed;
    wire logic two_speed = switchover_ff & ~sel_ff & crystal;
    wire logic su_done = su_cnt_ff == 11'(tscs_pkg::STARTUP_COUNT);
    wire logic put_expired = put_cnt_ff >= 32'(PUT_CYC);
    wire logic put_done = ~put_en_ff | put_expired;

    // start-up sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_su_cnt = su_cnt_ff;
        case (state_ff)
            tscs_pkg::ST_POWER_UP: begin
                nxt_su_cnt = 11'h0;
                if (put_done) begin
                    nxt_state = crystal ? tscs_pkg::ST_COUNT : tscs_pkg::ST_RUN_EXT;
                end
            end
            tscs_pkg::ST_COUNT: begin
                if (sleep_req) begin
                    nxt_state = tscs_pkg::ST_SLEEP;
                    nxt_su_cnt = 11'h0;
                end else if (su_done) begin
                    nxt_state = tscs_pkg::ST_WAIT_INT_FALL;
                end else if (ext_rise) begin
                    nxt_su_cnt = su_cnt_ff + 11'h1;
                end
            end
            tscs_pkg::ST_WAIT_INT_FALL: begin
                if (sleep_req) begin
                    nxt_state = tscs_pkg::ST_SLEEP;
                end else if (int_fall | ~two_speed) begin
                    nxt_state = tscs_pkg::ST_HOLD_LOW;
                end
            end
            tscs_pkg::ST_HOLD_LOW: begin
                if (ext_fall) begin
                    nxt_state = tscs_pkg::ST_RUN_EXT;
                end
            end
            tscs_pkg::ST_RUN_EXT: begin
                if (sleep_req) begin
                    nxt_state = tscs_pkg::ST_SLEEP;
                end
            end
            tscs_pkg::ST_SLEEP: begin
                nxt_su_cnt = 11'h0;
                if (wake_req) begin
                    nxt_state = crystal ? tscs_pkg::ST_COUNT : tscs_pkg::ST_RUN_EXT;
                end
            end
            default: begin
                nxt_state = tscs_pkg::ST_POWER_UP;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_ff <= tscs_pkg::ST_POWER_UP;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            su_cnt_ff <= 11'h0;
        end else begin
            su_cnt_ff <= nxt_su_cnt;
        end
    end

    // power-up timer runs only while waiting in its state
    wire logic put_tick = (state_ff == tscs_pkg::ST_POWER_UP) & ~put_done;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            put_cnt_ff <= 32'h0;
        end else if (put_tick) begin
            put_cnt_ff <= put_cnt_ff + 32'h1;
        end
    end

    // status bit: set from hold-low on, clear in start-up and sleep
    wire logic hold_next = nxt_state == tscs_pkg::ST_HOLD_LOW;
    wire logic run_next = nxt_state == tscs_pkg::ST_RUN_EXT;
    wire logic status_set = hold_next | run_next;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            status_ff <= 1'b0;
        end else begin
            status_ff <= status_set;
        end
    end

    // clock select and execution gate
    wire logic in_count = state_ff == tscs_pkg::ST_COUNT;
    wire logic in_wait = state_ff == tscs_pkg::ST_WAIT_INT_FALL;
    wire logic in_startup = in_count | in_wait;
    wire logic use_int = sel_ff | (in_startup & two_speed);
    wire logic hold_low = state_ff == tscs_pkg::ST_HOLD_LOW;
    wire logic run_ext = state_ff == tscs_pkg::ST_RUN_EXT;
    wire logic ext_path = run_ext ? sync2_ff.ext_osc : 1'b0;
    wire logic src_clk = use_int ? sync2_ff.int_osc : ext_path;
    wire logic nxt_sys_clk = hold_low ? 1'b0 : src_clk;
    wire logic nxt_exec = use_int | run_ext;

    // output stage
    logic sys_clk_ff;
    logic exec_ff;
    logic [2:0] int_freq_ff;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sys_clk_ff <= 1'b0;
        end else begin
            sys_clk_ff <= nxt_sys_clk;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            exec_ff <= 1'b0;
        end else begin
            exec_ff <= nxt_exec;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            int_freq_ff <= tscs_pkg::IFREQ_RESET;
        end else begin
            int_freq_ff <= ifreq_ff;
        end
    end

    assign sys_clk = sys_clk_ff;
    assign exec_en = exec_ff;
    assign int_freq_out = int_freq_ff;
    assign avs_readdata = avs_readdata_ff;
    assign avs_waitrequest = avs_wait_ff;
endmodule // tscs_switch
`default_nettype wire

// [tb/tscs_chk.sv]
// checker: port relations of the clock switch
`timescale 1ns/1ps
`default_nettype none
module tscs_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic exec_en,
    input wire logic [2:0] int_freq_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_ack;
        ##1 !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    chk_read_ack: assert property ($rose(avs_read) |-> s_ack)
        else $error("read not answered");
    chk_write_ack: assert property ($rose(avs_write) |-> s_ack)
        else $error("write not answered");
    chk_ack_cause: assert property (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
        else $error("answer without request");
    chk_unmapped_zero: assert property (!avs_waitrequest && $past(avs_read)
        && !($past(avs_address) inside {4'h0, 4'h4}) |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_data_hold: assert property ($changed(avs_readdata) |-> !avs_waitrequest)
        else $error("read data moved");
    chk_freq_reset: assert property ($rose(nrst) |-> int_freq_out == 3'h6)
        else $error("freq reset wrong");
    chk_freq_write: assert property ($changed(int_freq_out)
        |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
        else $error("freq moved alone");
    chk_exec_start: assert property ($rose(nrst) |-> ##[1:4] exec_en)
        else $error("no prompt execution");
endmodule // tscs_chk
bind tscs_switch tscs_chk tscs_chk_i (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .exec_en(exec_en), .int_freq_out(int_freq_out));
`default_nettype wire

// [tb/tscs_osc_model.sv]
// model: crystal and internal oscillators
`timescale 1ns/1ps
`default_nettype none
module tscs_osc_model (
    input wire logic run,
    output var tscs_pkg::tscs_osc_t osc
);
    logic int_q = 1'b0;
    logic ext_q = 1'b0;
    always #100 int_q = ~int_q;
    // crystal stands still at low while stopped
    always #62.5 ext_q = run ? ~ext_q : 1'b0;
    always_comb osc = '{int_osc: int_q, ext_osc: ext_q};
endmodule // tscs_osc_model
`default_nettype wire

// [tb/tscs_switch_tb.sv]
// testbench: registers and start-up of the clock switch
`timescale 1ns/1ps
`default_nettype none
module tscs_switch_tb;
    logic clk = 0, nrst = 0, sleep_req = 0, wake_req = 0, run = 1;
    logic avs_read = 0, avs_write = 0, avs_waitrequest, sys_clk, exec_en;
    logic [3:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, q;
    logic [2:0] int_freq_out;
    tscs_pkg::tscs_osc_t osc;
    int error_cnt = 0, num_checks = 0, cyc = 0, n;
    always #4 clk = ~clk;
    tscs_osc_model tscs_osc_model_i (.run(run), .osc(osc));
    tscs_switch #(.PUT_CYC(20)) tscs_switch_i (.clk(clk), .nrst(nrst), .osc_in(osc),
        .sleep_req(sleep_req), .wake_req(wake_req), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sys_clk(sys_clk), .exec_en(exec_en), .int_freq_out(int_freq_out));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task automatic nap;
        @(posedge clk);
        sleep_req <= 1;
        @(posedge clk);
        sleep_req <= 0;
        repeat (4) @(posedge clk);
        wake_req <= 1;
        @(posedge clk);
        wake_req <= 0;
    endtask
    task automatic toggles(input int len);
        logic p;
        n = 0;
        p = sys_clk;
        repeat (len) begin
            @(negedge clk);
            if (sys_clk !== p) n++;
            p = sys_clk;
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1;
        repeat (4) @(posedge clk);
        check(exec_en, 1);
        acc(0, 4'h0, 0);
        check(q, 32'h60);
        acc(0, 4'h4, 0);
        check(q, 32'h101);
        acc(0, 4'h8, 0);
        check(q, 32'h0);
        repeat (7800) @(negedge clk);
        acc(0, 4'h0, 0);
        check(q, 32'h60);
        check(exec_en, 1);
        @(posedge clk);
        sleep_req <= 1;
        run <= 0;
        @(posedge clk);
        sleep_req <= 0;
        repeat (20) @(posedge clk);
        wake_req <= 1;
        run <= 1;
        @(posedge clk);
        wake_req <= 0;
        repeat (9400) @(negedge clk);
        acc(0, 4'h0, 0);
        check(q, 32'h60);
        n = 0;
        while (q[3] !== 1'b1 && n < 900) begin
            repeat (10) @(negedge clk);
            n++;
            acc(0, 4'h0, 0);
        end
        check(q, 32'h68);
        toggles(800);
        check(n >= 100 && n <= 104, 1);
        acc(1, 4'h0, 32'h21);
        toggles(800);
        check(n >= 62 && n <= 66, 1);
        check(int_freq_out, 3'h2);
        acc(0, 4'h0, 0);
        check(q & 32'h71, 32'h21);
        acc(1, 4'h0, 32'h60);
        acc(1, 4'h4, 32'h4);
        nap();
        repeat (6) @(posedge clk);
        check(exec_en, 1);
        acc(0, 4'h0, 0);
        check(q, 32'h68);
        acc(1, 4'h4, 32'h1);
        nap();
        repeat (40) @(posedge clk);
        check(exec_en, 0);
        acc(0, 4'h0, 0);
        check(q, 32'h60);
        close_out();
    end
endmodule // tscs_switch_tb
`default_nettype wire
